// *** src/blx_pkg.sv ***
/*
 * Shared constants and types for the branch and call-with-return unit:
 * instruction field positions, the branch pattern, prefetch offsets,
 * condition codes, cycle-cost states.
 * Assumes 32-bit instruction words and byte addressing.
 */
package blx_pkg;

    localparam int          INSTR_W        = 32;
    localparam int          COND_FLD_HI    = 31;
    localparam int          COND_FLD_LO    = 28;
    localparam int          CLASS_HI       = 27;
    localparam int          CLASS_LO       = 25;
    localparam int          LINK_BIT       = 24;
    localparam int          DISP_HI        = 23;
    localparam int          DISP_W         = 24;
    localparam int          DISP_SHIFT     = 2;
    localparam int          EXT_W          = INSTR_W - DISP_W - DISP_SHIFT;

    localparam logic [2:0]  BRANCH_CLASS   = 3'h5;
    localparam logic [31:0] PREFETCH_BYTES = 32'h0000_0008;
    localparam logic [31:0] INSTR_BYTES    = 32'h0000_0004;
    localparam logic [31:0] LINK_ALIGN     = 32'hFFFF_FFFC;
    localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;

    // Two sequential plus one further cycle per taken branch
    localparam int          SEQ_CYCLES     = 2;
    localparam int          NSEQ_CYCLES    = 1;
    localparam int          TAKEN_CYCLES   = SEQ_CYCLES + NSEQ_CYCLES;

    typedef enum logic [3:0] {
        COND_EQ         = 4'h0,
        COND_NE         = 4'h1,
        COND_CS         = 4'h2,
        COND_CC         = 4'h3,
        COND_MI         = 4'h4,
        COND_PL         = 4'h5,
        COND_VS         = 4'h6,
        COND_VC         = 4'h7,
        COND_HI         = 4'h8,
        COND_LS         = 4'h9,
        COND_GE         = 4'hA,
        COND_LT         = 4'hB,
        COND_GT         = 4'hC,
        COND_LE         = 4'hD,
        COND_RUN_EVERY  = 4'hE,
        COND_RESERVED   = 4'hF
    } blx_cond_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FILL_N = 2'b01,
        ST_SEQ_1  = 2'b10,
        ST_SEQ_2  = 2'b11
    } blx_state_t;

endpackage : blx_pkg

// *** src/blx_cond_eval.sv ***
/*
 * Combinational condition-field evaluator.
 * Assumes the flags come from logic on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module blx_cond_eval
    import blx_pkg::*;
(
    input  wire logic [3:0] cond,
    input  wire logic       flag_n,
    input  wire logic       flag_z,
    input  wire logic       flag_c,
    input  wire logic       flag_v,
    output logic            pass,
    output logic            reserved
);

    always_comb begin
        pass     = 1'b0;
        reserved = 1'b0;
        unique case (blx_cond_t'(cond))
            COND_EQ:        pass = flag_z;
            COND_NE:        pass = !flag_z;
            COND_CS:        pass = flag_c;
            COND_CC:        pass = !flag_c;
            COND_MI:        pass = flag_n;
            COND_PL:        pass = !flag_n;
            COND_VS:        pass = flag_v;
            COND_VC:        pass = !flag_v;
            COND_HI:        pass = flag_c && !flag_z;
            COND_LS:        pass = !flag_c || flag_z;
            COND_GE:        pass = (flag_n == flag_v);
            COND_LT:        pass = (flag_n != flag_v);
            COND_GT:        pass = !flag_z && (flag_n == flag_v);
            COND_LE:        pass = flag_z || (flag_n != flag_v);
            COND_RUN_EVERY: pass = 1'b1;
            // Never executed; flagged so the pipeline can trap it
            COND_RESERVED:  reserved = 1'b1;
        endcase
    end

endmodule : blx_cond_eval
`default_nettype wire

// *** src/blx_branch_unit.sv ***
/*
 * Branch and call-with-return execution unit: decodes the branch class,
 * gates on the condition field, forms the target and return address,
 * and holds the core busy for the pipeline refill.
 * Assumes the fetch stage presents one instruction with its own address,
 * that flags are stable in the offer cycle, and all inputs share CORE_CLK.
 */
`timescale 1ns/1ps
`default_nettype none

module blx_branch_unit
    import blx_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    input  wire logic        CLK_EN,
    input  wire logic        INSTR_VALID,
    input  wire logic [31:0] INSTR_WORD,
    input  wire logic [31:0] INSTR_ADDR,
    input  wire logic        FLAG_N,
    input  wire logic        FLAG_Z,
    input  wire logic        FLAG_C,
    input  wire logic        FLAG_V,
    output logic             BUSY,
    output logic             PC_LOAD,
    output logic [31:0]      PC_TARGET,
    output logic             FETCH_FLUSH,
    output logic             LINK_WE,
    output logic [31:0]      LINK_DATA,
    output logic             SKIPPED,
    output logic             COND_FAULT
);

    function automatic logic is_branch(input logic [31:0] w);
        return w[CLASS_HI:CLASS_LO] == BRANCH_CLASS;
    endfunction : is_branch

    function automatic logic [31:0] scaled_disp(input logic [31:0] w);
        // Sign bit copied upward, word offset turned into bytes
        return {{EXT_W{w[DISP_HI]}}, w[DISP_HI:0], {DISP_SHIFT{1'b0}}};
    endfunction : scaled_disp

    blx_state_t  state_reg;
    blx_state_t  state_next;
    logic        cond_pass;
    logic        cond_rsvd;
    logic        offer;
    logic        take;
    logic        skip;
    logic [31:0] pc_ahead;
    logic [31:0] target_next;
    logic [31:0] link_next;
    logic        busy_reg;
    logic        pc_load_reg;
    logic [31:0] pc_target_reg;
    logic        flush_reg;
    logic        link_we_reg;
    logic [31:0] link_data_reg;
    logic        skipped_reg;
    logic        fault_reg;

    blx_cond_eval u_cond (
        .cond     (INSTR_WORD[COND_FLD_HI:COND_FLD_LO]),
        .flag_n   (FLAG_N),
        .flag_z   (FLAG_Z),
        .flag_c   (FLAG_C),
        .flag_v   (FLAG_V),
        .pass     (cond_pass),
        .reserved (cond_rsvd)
    );

    // Offers during a refill are not taken; fetch is being redirected anyway
    assign offer       = INSTR_VALID && (state_reg == ST_IDLE) && is_branch(INSTR_WORD);
    assign take        = offer && cond_pass && !cond_rsvd;
    assign skip        = offer && !take;
    assign pc_ahead    = INSTR_ADDR + PREFETCH_BYTES;
    assign target_next = pc_ahead + scaled_disp(INSTR_WORD);
    // Back off one word from the prefetch PC, low bits dropped
    assign link_next   = (pc_ahead - INSTR_BYTES) & LINK_ALIGN;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (take) begin
                state_next = ST_FILL_N;
            end
            ST_FILL_N: state_next = ST_SEQ_1;
            ST_SEQ_1:  state_next = ST_SEQ_2;
            ST_SEQ_2:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
        end else if (CLK_EN) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_reg <= 1'b0;
        end else if (CLK_EN) begin
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pc_load_reg   <= 1'b0;
            flush_reg     <= 1'b0;
            pc_target_reg <= ADDR_RESET;
        end else if (CLK_EN) begin
            pc_load_reg <= take;
            flush_reg   <= take;
            // Target held after the pulse; fetch may sample it late
            if (take) begin
                pc_target_reg <= target_next;
            end
        end
    end

    // Only the return address goes out; status word is never copied
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            link_we_reg   <= 1'b0;
            link_data_reg <= ADDR_RESET;
        end else if (CLK_EN) begin
            link_we_reg <= take && INSTR_WORD[LINK_BIT];
            if (take && INSTR_WORD[LINK_BIT]) begin
                link_data_reg <= link_next;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            skipped_reg <= 1'b0;
            fault_reg   <= 1'b0;
        end else if (CLK_EN) begin
            skipped_reg <= skip;
            fault_reg   <= offer && cond_rsvd;
        end
    end

    // Ports straight from registers so fetch sees no decode glitches
    assign BUSY        = busy_reg;
    assign PC_LOAD     = pc_load_reg;
    assign PC_TARGET   = pc_target_reg;
    assign FETCH_FLUSH = flush_reg;
    assign LINK_WE     = link_we_reg;
    assign LINK_DATA   = link_data_reg;
    assign SKIPPED     = skipped_reg;
    assign COND_FAULT  = fault_reg;

    // Freezing the clock enable aborts checks in flight
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B || !CLK_EN);

    skip_no_effect_a: assert property (skip |=> !PC_LOAD && !LINK_WE && SKIPPED)
        else $error("failed condition still changed PC or link");
    link_bit_select_a: assert property (take |=> PC_LOAD && (LINK_WE == $past(INSTR_WORD[LINK_BIT])))
        else $error("link write does not follow bit 24");
    target_sum_a: assert property (take |=> PC_TARGET == $past(INSTR_ADDR) + 32'h0000_0008
            + {{6{$past(INSTR_WORD[23])}}, $past(INSTR_WORD[23:0]), 2'b00})
        else $error("branch target miscomputed");
    negative_disp_a: assert property (take && INSTR_WORD[23:0] == 24'hFFFFFE
            |=> PC_TARGET == $past(INSTR_ADDR))
        else $error("negative displacement not sign-extended");
    return_addr_a: assert property (take && INSTR_WORD[LINK_BIT]
            |=> LINK_WE && LINK_DATA == (($past(INSTR_ADDR) + 32'h0000_0004) & 32'hFFFF_FFFC))
        else $error("return address wrong");
    link_low_zero_a: assert property (LINK_WE |-> LINK_DATA[1:0] == 2'b00)
        else $error("link bits 1:0 not cleared");
    refill_cost_a: assert property ($rose(BUSY) |-> PC_LOAD ##0 BUSY[*3] ##1 !BUSY)
        else $error("taken branch not three cycles");
    plain_keeps_link_a: assert property (take && !INSTR_WORD[LINK_BIT]
            |=> !LINK_WE && $stable(LINK_DATA))
        else $error("plain branch touched link register");
    always_taken_a: assert property (offer
            && INSTR_WORD[COND_FLD_HI:COND_FLD_LO] == COND_RUN_EVERY |=> PC_LOAD)
        else $error("run-every-time branch not taken");
    flush_with_load_a: assert property (PC_LOAD |-> FETCH_FLUSH && BUSY)
        else $error("taken branch without flush");
    // Refused offers during refill must not raise PC_LOAD, SKIPPED or LINK_WE
    busy_refuses_a: assert property (BUSY |=> !PC_LOAD && !SKIPPED && !LINK_WE)
        else $error("offer accepted during pipeline refill");
    skip_no_refill_a: assert property (skip |=> !BUSY)
        else $error("failed condition started a refill");
    non_branch_quiet_a: assert property (INSTR_VALID && !is_branch(INSTR_WORD)
            |=> !PC_LOAD && !SKIPPED && !COND_FAULT)
        else $error("non-branch word acted on");
    fault_not_taken_a: assert property (COND_FAULT |-> SKIPPED && !PC_LOAD && !LINK_WE)
        else $error("reserved condition executed");
    load_single_a: assert property (PC_LOAD |=> !PC_LOAD && !FETCH_FLUSH)
        else $error("load pulse longer than one cycle");
    // Outputs that hold may only move together with their strobe
    link_hold_a: assert property (!LINK_WE |-> $stable(LINK_DATA))
        else $error("link data moved without write");
    target_hold_a: assert property (!PC_LOAD |-> $stable(PC_TARGET))
        else $error("target moved without load");

    plain_taken_c: cover property (take && !INSTR_WORD[LINK_BIT] ##1 PC_LOAD);
    call_taken_c: cover property (take && INSTR_WORD[LINK_BIT] ##1 LINK_WE);
    skipped_c: cover property (skip && !cond_rsvd);
    reserved_c: cover property (offer && cond_rsvd ##1 COND_FAULT);
    refused_offer_c: cover property (BUSY && INSTR_VALID && is_branch(INSTR_WORD));

endmodule : blx_branch_unit
`default_nettype wire

// *** dv/tb_branch_link_execution.sv ***
/*
 * Self-checking bench for the branch and call-with-return unit.
 * Assumes blx_pkg and blx_branch_unit are compiled first; drives at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_branch_link_execution;
    import blx_pkg::*;

    logic        core_clk    = 1'b0;
    logic        rst_b       = 1'b0;
    logic        clk_en      = 1'b1;
    logic        instr_valid = 1'b0;
    logic [31:0] instr_word  = 32'h0;
    logic [31:0] instr_addr  = 32'h0;
    logic [3:0]  flags       = 4'h0;
    logic        busy, pc_load, fetch_flush, link_we, skipped, cond_fault;
    logic [31:0] pc_target, link_data;
    logic [31:0] rnd = 32'h16;
    logic [31:0] exp_pc = 32'h0;
    logic [31:0] exp_lr = 32'h0;
    logic [3:0]  cnd    = 4'h0;
    int          fail_count = 0;
    int          n_compared = 0;

    always #5 core_clk = ~core_clk;

    blx_branch_unit blx_branch_unit_i (
        .CORE_CLK(core_clk), .RST_B(rst_b), .CLK_EN(clk_en), .INSTR_VALID(instr_valid),
        .INSTR_WORD(instr_word), .INSTR_ADDR(instr_addr), .FLAG_N(flags[3]),
        .FLAG_Z(flags[2]), .FLAG_C(flags[1]), .FLAG_V(flags[0]), .BUSY(busy),
        .PC_LOAD(pc_load), .PC_TARGET(pc_target), .FETCH_FLUSH(fetch_flush),
        .LINK_WE(link_we), .LINK_DATA(link_data), .SKIPPED(skipped), .COND_FAULT(cond_fault)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Byte target and return address as the rules state them
    function automatic logic [31:0] exp_target(input logic [31:0] w, input logic [31:0] a);
        return a + 32'h0000_0008 + {{6{w[23]}}, w[23:0], 2'b00};
    endfunction : exp_target

    function automatic logic [31:0] exp_return(input logic [31:0] a);
        return (a + 32'h0000_0004) & 32'hFFFF_FFFC;
    endfunction : exp_return

    // Flags packed as N, Z, C, V
    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        {n, z, cy, v} = f;
        case (c)
            4'h0: return z;
            4'h1: return !z;
            4'h2: return cy;
            4'h3: return !cy;
            4'h4: return n;
            4'h5: return !n;
            4'h6: return v;
            4'h7: return !v;
            4'h8: return cy && !z;
            4'h9: return !cy || z;
            4'hA: return n == v;
            4'hB: return n != v;
            4'hC: return !z && (n == v);
            4'hD: return z || (n != v);
            4'hE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : cond_ok

    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic check_idle;
        `CHK(pc_load, 1'b0)
        `CHK(link_we, 1'b0)
        `CHK(skipped, 1'b0)
        `CHK(pc_target, exp_pc)
        `CHK(link_data, exp_lr)
    endtask : check_idle

    // Offer one word; when taken, follow the refill with refused offers inside it
    task automatic offer(input logic [31:0] w, input logic [31:0] a, input logic [3:0] f);
        logic br, tk;
        instr_valid = 1'b1;
        instr_word  = w;
        instr_addr  = a;
        flags       = f;
        @(negedge core_clk);
        br = (w[27:25] === 3'h5);
        tk = br && cond_ok(w[31:28], f);
        if (tk) begin
            exp_pc = exp_target(w, a);
            if (w[24]) begin
                exp_lr = exp_return(a);
            end
        end
        `CHK(pc_load, tk)
        `CHK(fetch_flush, tk)
        `CHK(busy, tk)
        `CHK(skipped, br && !tk)
        `CHK(cond_fault, br && (w[31:28] == 4'hF))
        `CHK(link_we, tk && w[24])
        `CHK(pc_target, exp_pc)
        `CHK(link_data, exp_lr)
        if (tk) begin
            for (int i = 1; i <= 3; i++) begin
                rnd = lfsr_next(rnd);
                instr_word = {4'hE, 3'h5, rnd[24:0]};
                instr_addr = rnd & 32'hFFFF_FFFC;
                @(negedge core_clk);
                `CHK(busy, (i < 3) ? 1'b1 : 1'b0)
                check_idle();
            end
        end
    endtask : offer

    initial begin
        repeat (12) @(posedge core_clk);
        `CHK(pc_target, 32'h0)
        `CHK(busy, 1'b0)
        @(negedge core_clk);
        rst_b = 1'b1;
        // Displacement extremes, address wrap, non-branch, reserved code, EQ skipped then EQ taken
        offer({4'hE, 3'h5, 1'b1, 24'h7FFFFF}, 32'h0000_1000, 4'h0);
        offer({4'hE, 3'h5, 1'b0, 24'h800000}, 32'h0200_0000, 4'h0);
        offer({4'hE, 3'h5, 1'b1, 24'hFFFFFF}, 32'hFFFF_FFFC, 4'h0);
        offer({4'hE, 3'h4, 1'b1, 24'h000010}, 32'h0000_0040, 4'h0);
        offer({4'hF, 3'h5, 1'b1, 24'h000010}, 32'h0000_0080, 4'hF);
        offer({4'h0, 3'h5, 1'b1, 24'h000004}, 32'h0000_0100, 4'h0);
        offer({4'h0, 3'h5, 1'b1, 24'h000004}, 32'h0000_0104, 4'h4);
        for (int k = 0; k < 400; k++) begin
            rnd = lfsr_next(rnd);
            // Reserved code kept out of random traffic; sent once on purpose above
            cnd = (rnd[31:28] == 4'hF) ? 4'hE : rnd[31:28];
            offer({cnd, (rnd[3:1] == 3'h0) ? rnd[27:25] : 3'h5, rnd[24:0]},
                  lfsr_next(rnd) & 32'hFFFF_FFFC, rnd[7:4]);
        end
        // A frozen clock enable ignores an offer that would be taken
        instr_valid = 1'b0;
        @(negedge core_clk);
        clk_en      = 1'b0;
        instr_valid = 1'b1;
        instr_word  = {4'hE, 3'h5, 1'b1, 24'h000100};
        @(negedge core_clk);
        `CHK(busy, 1'b0)
        check_idle();
        clk_en      = 1'b1;
        instr_valid = 1'b0;
        @(negedge core_clk);
        // Reset in mid-refill clears busy, target and link data at once
        offer({4'hE, 3'h5, 1'b0, 24'h000020}, 32'h0000_0200, 4'h0);
        instr_valid = 1'b1;
        instr_word  = {4'hE, 3'h5, 1'b1, 24'h000020};
        @(negedge core_clk);
        rst_b = 1'b0;
        #1;
        `CHK(busy, 1'b0)
        `CHK(pc_target, 32'h0)
        `CHK(link_data, 32'h0)
        @(negedge core_clk);
        rst_b       = 1'b1;
        instr_valid = 1'b0;
        exp_pc      = 32'h0;
        exp_lr      = 32'h0;
        // First two edges after release stay quiet, then a call runs normally
        repeat (2) begin
            @(negedge core_clk);
            `CHK(busy, 1'b0)
            check_idle();
        end
        offer({4'hE, 3'h5, 1'b1, 24'h000020}, 32'h0000_0300, 4'h0);
        test_done();
    end

    // Roughly 1000 cycles expected; generous margin
    initial begin
        #200000;
        fail_count++;
        test_done();
    end

endmodule : tb_branch_link_execution
`default_nettype wire
